/* rsc_top.sv */
/*
  rsc_top: rename and alias-table stall event counter with a classic
  Wishbone register slave. Holds the partial-flag detector, the segment
  rename trackers that stall the front end, the event-select and count
  registers. Assumes all pipeline inputs are synchronous to clk_i and
  each stall input is high for exactly the cycles it describes.
*/
// Our own choices: the Wishbone slave port and the register addresses.
// Summary of operation
// - count partial register stall cycles, D2/02
// - count flag stall cycles, D2/04
// - reading flags a partial writer skipped stalls
// - fp status word write adds two, D2/08
// - D2/0F counts any of four stall kinds
// - D4/01 counts extra segment rename stalls
// - D4/02 counts data segment rename stalls
// - D4/04 counts f segment rename stalls
// - D4/08 counts g segment rename stalls
// - D4/0F counts rename stalls on any segment
// - second update stalls until renamed copy retires
// - D2/01 counts reorder buffer read port stalls
module rsc_top (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  // classic wishbone slave
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [rsc_pkg::RSC_ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                         wb_sel_i,
  input  wire logic [rsc_pkg::RSC_DAT_W-1:0]      wb_dat_i,
  output logic      [rsc_pkg::RSC_DAT_W-1:0]      wb_dat_o,
  output logic                                    wb_ack_o,
  // alias table stall sources
  input  wire logic                               reorder_buffer_read_port_stall_i,
  input  wire logic                               partial_register_stall_i,
  input  wire logic                               other_flag_stall_i,
  input  wire logic                               fp_status_word_write_i,
  // flag producers and consumers
  input  wire logic                               flag_write_valid_i,
  input  wire logic [rsc_pkg::RSC_FLAG_W-1:0]     flag_write_mask_i,
  input  wire logic                               flag_read_valid_i,
  input  wire logic [rsc_pkg::RSC_FLAG_W-1:0]     flag_read_mask_i,
  // segment rename tracking
  input  wire logic [rsc_pkg::RSC_NUM_SEG-1:0]    segment_update_i,
  input  wire logic [rsc_pkg::RSC_NUM_SEG-1:0]    segment_retire_i,
  output logic      [rsc_pkg::RSC_NUM_SEG-1:0]    front_end_stall_o,
  // partial flag stall indication
  output logic                                    partial_flag_stall_o
);
  import rsc_pkg::*;

  rsc_evt_if ev ();                               // events to the selector

  logic [31:0]             evtsel_r;              // event select register
  logic [31:0]             count_r;               // event count register
  logic                    ack_r;                 // bus acknowledge
  logic [31:0]             rdat_r;                // registered read data
  logic [RSC_FLAG_W-1:0]   last_flag_mask_r;      // flags set by last writer
  logic [RSC_NUM_SEG-1:0]  seg_pend_r;            // renamed, not yet retired
  logic [RSC_NUM_SEG-1:0]  seg_stall;             // stall asserted this cycle
  logic [RSC_NUM_SEG-1:0]  seg_stall_d_r;         // stall one cycle earlier
  logic                    pflag;                 // partial flag stall
  logic                    flag_stall_cycles;     // any flag stall this cycle
  logic                    bus_req;               // request present
  logic                    bus_wr;                // write taken this edge
  logic                    cnt_wr;                // write hits count register

  // per-segment named views of the stall starts
  logic segment_rename_stall_extra;
  logic segment_rename_stall_data;
  logic segment_rename_stall_f;
  logic segment_rename_stall_g;
  logic segment_rename_stall_any;

  // merge a write under byte enables
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // bus request decode; writes land on the acknowledging edge only
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & wb_we_i & ack_r;
  assign cnt_wr  = bus_wr & (wb_adr_i == RSC_OFS_COUNT);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // read data captured with the ack; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (bus_req & ~ack_r) begin
      case (wb_adr_i)
        RSC_OFS_EVTSEL: rdat_r <= evtsel_r;
        RSC_OFS_COUNT:  rdat_r <= count_r;
        RSC_OFS_STATUS: begin
          rdat_r                                  <= 32'h0000_0000;
          rdat_r[RSC_ST_PEND_LSB +: RSC_NUM_SEG]  <= seg_pend_r;
          rdat_r[RSC_ST_STALL_LSB +: RSC_NUM_SEG] <= seg_stall;
          rdat_r[RSC_ST_PFLAG_BIT]                <= pflag;
          rdat_r[RSC_ST_EN_BIT]                   <= evtsel_r[RSC_SEL_EN_BIT];
        end
        default:        rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // event select register; only code, mask and enable bits are kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evtsel_r <= RSC_EVTSEL_RST;
    end else if (bus_wr & (wb_adr_i == RSC_OFS_EVTSEL)) begin
      evtsel_r <= wb_merge(evtsel_r, wb_dat_i, wb_sel_i) & 32'h0001_FFFF;
    end
  end

  // count register: a software write beats the increment of that cycle,
  // so a freshly written value is never off by one event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= RSC_COUNT_RST;
    end else if (cnt_wr) begin
      count_r <= wb_merge(count_r, wb_dat_i, wb_sel_i);
    end else begin
      count_r <= count_r + {{(32-RSC_INC_W){1'b0}}, ev.inc};
    end
  end

  // remember which flags the most recent writer touched; reset means a
  // full write, so no stall can be reported before any flag producer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_flag_mask_r <= RSC_FLAGS_ALL;
    end else if (flag_write_valid_i) begin
      last_flag_mask_r <= flag_write_mask_i;
    end
  end

  // a consumer that needs flags the last partial writer left alone stalls
  assign pflag = flag_read_valid_i & (last_flag_mask_r != RSC_FLAGS_ALL) &
                 (|(flag_read_mask_i & ~last_flag_mask_r));
  assign partial_flag_stall_o = pflag;
  assign flag_stall_cycles    = pflag | other_flag_stall_i;

  // segment rename trackers, one per segment register
  for (genvar s = 0; s < RSC_NUM_SEG; s++) begin : g_seg
    // an update while an older copy is in flight is held off
    assign seg_stall[s] = segment_update_i[s] & seg_pend_r[s] &
                          ~segment_retire_i[s];

    // retire in the same cycle frees the slot, so the update goes through
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        seg_pend_r[s] <= 1'b0;
      end else if (segment_update_i[s] & ~seg_stall[s]) begin
        seg_pend_r[s] <= 1'b1;
      end else if (segment_retire_i[s]) begin
        seg_pend_r[s] <= 1'b0;
      end
    end

    // previous stall state, to count each stall once rather than per cycle
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        seg_stall_d_r[s] <= 1'b0;
      end else begin
        seg_stall_d_r[s] <= seg_stall[s];
      end
    end
  end

  assign front_end_stall_o          = seg_stall;
  assign segment_rename_stall_extra = seg_stall[0] & ~seg_stall_d_r[0];
  assign segment_rename_stall_data  = seg_stall[1] & ~seg_stall_d_r[1];
  assign segment_rename_stall_f     = seg_stall[2] & ~seg_stall_d_r[2];
  assign segment_rename_stall_g     = seg_stall[3] & ~seg_stall_d_r[3];
  assign segment_rename_stall_any   = |(seg_stall & ~seg_stall_d_r);

  // feed the selector
  assign ev.enable     = evtsel_r[RSC_SEL_EN_BIT];
  assign ev.evt_code   = evtsel_r[RSC_SEL_CODE_LSB +: 8];
  assign ev.umask      = evtsel_r[RSC_SEL_MASK_LSB +: 8];
  assign ev.rdport_stall = reorder_buffer_read_port_stall_i;
  assign ev.preg_stall = partial_register_stall_i;
  assign ev.flag_stall = flag_stall_cycles;
  assign ev.fpstat_write = fp_status_word_write_i;
  assign ev.seg_start  = {segment_rename_stall_g, segment_rename_stall_f,
                          segment_rename_stall_data, segment_rename_stall_extra};

  rsc_event_sel rsc_event_sel_inst (
    .ev (ev)
  );

  // checks on counting and stalling
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic sel_on;                                   // counting enabled, no write
  assign sel_on = evtsel_r[RSC_SEL_EN_BIT] & ~cnt_wr;

  property p_preg;
    (sel_on && evtsel_r[15:0] == 16'h02D2 && partial_register_stall_i)
      |=> count_r == $past(count_r) + 32'h1;
  endproperty
  a_preg: assert property (p_preg) else $error("partial reg stall not counted");

  property p_flag;
    (sel_on && evtsel_r[15:0] == 16'h04D2 && flag_stall_cycles)
      |=> count_r == $past(count_r) + 32'h1;
  endproperty
  a_flag: assert property (p_flag) else $error("flag stall not counted");

  // a partial writer followed by a consumer of a flag it left alone
  property p_pflag;
    (flag_write_valid_i && flag_write_mask_i != RSC_FLAGS_ALL) ##1
    (!flag_write_valid_i && flag_read_valid_i &&
     (flag_read_mask_i & ~$past(flag_write_mask_i)) != 6'h00) |-> pflag;
  endproperty
  a_pflag: assert property (p_pflag) else $error("partial flag stall missed");

  property p_fpstat;
    (sel_on && evtsel_r[15:0] == 16'h08D2 && fp_status_word_write_i)
      |=> count_r == $past(count_r) + 32'h2;
  endproperty
  a_fpstat: assert property (p_fpstat) else $error("fp status word write not two");

  property p_any;
    (sel_on && evtsel_r[15:0] == 16'h0FD2 &&
     (reorder_buffer_read_port_stall_i || partial_register_stall_i ||
      flag_stall_cycles || fp_status_word_write_i))
      |=> count_r == $past(count_r) + 32'h1;
  endproperty
  a_any: assert property (p_any) else $error("alias table any not counted");

  property p_seg_es;
    (sel_on && evtsel_r[15:0] == 16'h01D4 && seg_stall[0] && !seg_stall_d_r[0])
      |=> count_r == $past(count_r) + 32'h1;
  endproperty
  a_seg_es: assert property (p_seg_es) else $error("extra seg stall not counted");

  property p_seg_any;
    (sel_on && evtsel_r[15:0] == 16'h0FD4 && (seg_stall & ~seg_stall_d_r) == 4'hF)
      |=> count_r == $past(count_r) + 32'h4;
  endproperty
  a_seg_any: assert property (p_seg_any) else $error("any seg stall miscounted");

  property p_hold;
    (segment_update_i[0] && !segment_retire_i[0] && !seg_pend_r[0])
      ##1 (segment_update_i[0] && !segment_retire_i[0])
      |-> front_end_stall_o[0] ##1 seg_pend_r[0];
  endproperty
  a_hold: assert property (p_hold) else $error("second update not stalled");

  property p_rdport;
    (sel_on && evtsel_r[15:0] == 16'h01D2 && !reorder_buffer_read_port_stall_i)
      |=> count_r == $past(count_r);
  endproperty
  a_rdport: assert property (p_rdport) else $error("read port event counted without stall");

  property p_unlisted;
    (~cnt_wr && evtsel_r[7:0] != 8'hD2 && evtsel_r[7:0] != 8'hD4)
      |=> $stable(count_r);
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted code counted");

  c_fpstat: cover property (sel_on && evtsel_r[15:0] == 16'h08D2 && fp_status_word_write_i);
  c_stall: cover property (front_end_stall_o[1] ##1 segment_retire_i[1]);
  c_pflag: cover property (pflag && evtsel_r[RSC_SEL_EN_BIT]);

endmodule

/* rsc_pkg.sv */
/*
  rsc_pkg: shared constants for the rename/alias-table stall event counter.
  Holds register offsets, field positions, reset values, event encodings
  and widths. Assumes it is compiled before every other file of the block.
*/
package rsc_pkg;

  // register bus geometry
  localparam int          RSC_ADR_W       = 4;
  localparam int          RSC_DAT_W       = 32;
  localparam logic [3:0]  RSC_OFS_EVTSEL  = 4'h0;
  localparam logic [3:0]  RSC_OFS_COUNT   = 4'h4;
  localparam logic [3:0]  RSC_OFS_STATUS  = 4'h8;

  // event select register fields
  localparam int          RSC_SEL_CODE_LSB = 0;
  localparam int          RSC_SEL_MASK_LSB = 8;
  localparam int          RSC_SEL_EN_BIT   = 16;
  localparam logic [31:0] RSC_EVTSEL_RST   = 32'h0000_0000;
  localparam logic [31:0] RSC_COUNT_RST    = 32'h0000_0000;

  // status register fields
  localparam int          RSC_ST_PEND_LSB  = 0;
  localparam int          RSC_ST_STALL_LSB = 4;
  localparam int          RSC_ST_PFLAG_BIT = 8;
  localparam int          RSC_ST_EN_BIT    = 9;

  // event codes and unit masks
  localparam logic [7:0]  RSC_EVT_ALIAS    = 8'hD2;
  localparam logic [7:0]  RSC_EVT_SEG      = 8'hD4;
  localparam logic [7:0]  RSC_UM_01        = 8'h01;
  localparam logic [7:0]  RSC_UM_02        = 8'h02;
  localparam logic [7:0]  RSC_UM_04        = 8'h04;
  localparam logic [7:0]  RSC_UM_08        = 8'h08;
  localparam logic [7:0]  RSC_UM_ANY       = 8'h0F;

  // increment sizing
  localparam int          RSC_INC_W        = 3;
  localparam logic [2:0]  RSC_FPSTAT_WEIGHT = 3'h2;

  // segment registers: 0 extra, 1 data, 2 f, 3 g
  localparam int          RSC_NUM_SEG      = 4;

  // flag register width and the all-flags mask
  localparam int          RSC_FLAG_W       = 6;
  localparam logic [5:0]  RSC_FLAGS_ALL    = 6'h3F;

endpackage

/* rsc_evt_if.sv */
/*
  rsc_evt_if: carries the qualified pipeline events and the programmed
  selection from the top module to the event selector, and the resulting
  increment back. Assumes rsc_pkg is compiled first.
*/
interface rsc_evt_if;
  import rsc_pkg::*;

  logic                   enable;       // counting enabled
  logic [7:0]             evt_code;     // programmed event code
  logic [7:0]             umask;        // programmed unit mask
  logic                   rdport_stall; // reorder buffer read port stall
  logic                   preg_stall;   // partial register stall cycle
  logic                   flag_stall;   // flag stall cycle
  logic                   fpstat_write; // fp status word written
  logic [RSC_NUM_SEG-1:0] seg_start;    // segment rename stall begins
  logic [RSC_INC_W-1:0]   inc;          // amount to add this cycle

  modport src (output enable, evt_code, umask, rdport_stall, preg_stall,
               flag_stall, fpstat_write, seg_start, input inc);
  modport sel (input enable, evt_code, umask, rdport_stall, preg_stall,
               flag_stall, fpstat_write, seg_start, output inc);
endinterface

/* rsc_event_sel.sv */
/*
  rsc_event_sel: decodes event code and unit mask into a per-cycle
  increment. Purely combinational. Assumes the source side drives every
  event as a one-cycle-per-occurrence level aligned to the clock.
*/
module rsc_event_sel (
  // event and selection carrier
  rsc_evt_if.sel ev
);
  import rsc_pkg::*;

  logic [RSC_INC_W-1:0] inc_nxt;  // decoded increment before enable gate
  logic [RSC_INC_W-1:0] seg_cnt;  // number of segments starting a stall

  // popcount of segment stall starts, for the any-segment event
  always_comb begin
    seg_cnt = '0;
    for (int i = 0; i < RSC_NUM_SEG; i++) begin
      seg_cnt = seg_cnt + {{(RSC_INC_W-1){1'b0}}, ev.seg_start[i]};
    end
  end

  // unknown encodings fall to zero so nothing is counted by accident
  always_comb begin
    inc_nxt = '0;
    case (ev.evt_code)
      RSC_EVT_ALIAS: begin
        case (ev.umask)
          RSC_UM_01:  inc_nxt = {2'b00, ev.rdport_stall};
          RSC_UM_02:  inc_nxt = {2'b00, ev.preg_stall};
          RSC_UM_04:  inc_nxt = {2'b00, ev.flag_stall};
          RSC_UM_08:  inc_nxt = ev.fpstat_write ? RSC_FPSTAT_WEIGHT : 3'h0;
          // union: one per cycle whatever mix of the four is present
          RSC_UM_ANY: inc_nxt = {2'b00, ev.rdport_stall | ev.preg_stall |
                                        ev.flag_stall | ev.fpstat_write};
          default:    inc_nxt = '0;
        endcase
      end
      RSC_EVT_SEG: begin
        case (ev.umask)
          RSC_UM_01:  inc_nxt = {2'b00, ev.seg_start[0]};
          RSC_UM_02:  inc_nxt = {2'b00, ev.seg_start[1]};
          RSC_UM_04:  inc_nxt = {2'b00, ev.seg_start[2]};
          RSC_UM_08:  inc_nxt = {2'b00, ev.seg_start[3]};
          RSC_UM_ANY: inc_nxt = seg_cnt;
          default:    inc_nxt = '0;
        endcase
      end
      default: inc_nxt = '0;
    endcase
  end

  // a disabled counter adds nothing
  assign ev.inc = ev.enable ? inc_nxt : '0;

endmodule

/* rsc_pipe_model.sv */
/*
  rsc_pipe_model: behavioural model of the pipeline rename logic that
  faces the counter. Issues segment updates on command, holds each one
  while the front end is stalled, and retires a renamed copy a fixed
  number of cycles after it was accepted. Assumes one clock shared with
  the block and that issue_i pulses last one cycle.
*/
module rsc_pipe_model #(
  parameter int RET_DLY = 8  // cycles from rename to retire, at least 2
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // commands from the bench
  input  wire logic [3:0] issue_i,
  // rename interface of the block
  input  wire logic [3:0] front_end_stall_i,
  output logic      [3:0] segment_update_o,
  output logic      [3:0] segment_retire_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int tmr [4];  // cycles left until the renamed copy retires

  // update request and retire timer per segment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      segment_update_o <= 4'h0;
      for (int s = 0; s < 4; s++) tmr[s] <= 0;
    end else begin
      for (int s = 0; s < 4; s++) begin
        // held until the front end lets it through
        if (issue_i[s]) segment_update_o[s] <= 1'b1;
        else if (segment_update_o[s] && !front_end_stall_i[s]) segment_update_o[s] <= 1'b0;
        // an accepted update starts a fresh rename lifetime
        if (segment_update_o[s] && !front_end_stall_i[s]) tmr[s] <= RET_DLY;
        else if (tmr[s] != 0) tmr[s] <= tmr[s] - 1;
      end
    end
  end

  // retire pulses for exactly one cycle, when the timer hits one
  always_comb begin
    for (int s = 0; s < 4; s++) segment_retire_o[s] = (tmr[s] == 1);
  end
endmodule

/* rename_stall_event_counting_bench.sv */
/*
  rename_stall_event_counting_bench: self-checking bench for rsc_top.
  Drives the register bus and the stall sources, uses the pipeline model
  for segment renames. Assumes rsc_pkg and the design files compile first.
*/
module rename_stall_event_counting_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;

  logic        clk_i, rst_i;                 // clock and reset
  logic        wb_cyc, wb_stb, wb_we;        // bus request
  logic [3:0]  wb_adr, wb_sel;
  logic [31:0] wb_dat, wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  src;                          // {read port, preg, other flag, fp status}
  logic        fw_v, fr_v;                   // flag producer and consumer
  logic [5:0]  fw_m, fr_m;
  logic [3:0]  issue, upd, ret, fes;         // segment rename traffic
  logic        pfs;
  int          err_total, n_compared;

  rsc_top rsc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reorder_buffer_read_port_stall_i(src[3]), .partial_register_stall_i(src[2]),
    .other_flag_stall_i(src[1]), .fp_status_word_write_i(src[0]),
    .flag_write_valid_i(fw_v), .flag_write_mask_i(fw_m),
    .flag_read_valid_i(fr_v), .flag_read_mask_i(fr_m),
    .segment_update_i(upd), .segment_retire_i(ret),
    .front_end_stall_o(fes), .partial_flag_stall_o(pfs));

  rsc_pipe_model rsc_pipe_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .issue_i(issue), .front_end_stall_i(fes),
    .segment_update_o(upd), .segment_retire_o(ret));

  // free running clock, 4 ns
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // one closing point for the run
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle; waits for ack under a bounded count
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);  // ack never came
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  // program selection and clear the count
  task automatic set_evt(input logic [7:0] c, input logic [7:0] u, input logic en);
    logic [31:0] q;
    wb(1'b1, RSC_OFS_EVTSEL, {15'h0, en, u, c}, q);
    wb(1'b1, RSC_OFS_COUNT, 32'h0, q);
  endtask

  // hold a source pattern high for n cycles
  task automatic drive(input logic [3:0] v, input int n);
    @(posedge clk_i);
    src <= v;
    repeat (n) @(posedge clk_i);
    src <= 4'h0;
  endtask

  // reset values, field masking, unmapped place, status
  task automatic t_regs();
    logic [31:0] q;
    rd_chk(RSC_OFS_EVTSEL, RSC_EVTSEL_RST);
    rd_chk(RSC_OFS_COUNT, RSC_COUNT_RST);
    rd_chk(4'hC, 32'h0);
    wb(1'b1, RSC_OFS_EVTSEL, 32'hFFFF_FFFF, q);
    rd_chk(RSC_OFS_EVTSEL, 32'h0001_FFFF);
    rd_chk(RSC_OFS_STATUS, 32'h0000_0200);
  endtask

  // every alias table mask against a fixed source pattern: 1,2,3,1 cycles
  task automatic t_alias();
    logic [7:0]  um [5] = '{RSC_UM_01, RSC_UM_02, RSC_UM_04, RSC_UM_08, RSC_UM_ANY};
    logic [31:0] ex [5] = '{32'd1, 32'd2, 32'd3, 32'd2, 32'd7};
    for (int i = 0; i < 5; i++) begin
      set_evt(RSC_EVT_ALIAS, um[i], 1'b1);
      drive(4'b1000, 1);
      drive(4'b0100, 2);
      drive(4'b0010, 3);
      drive(4'b0001, 1);
      rd_chk(RSC_OFS_COUNT, ex[i]);
    end
  endtask

  // partial flag write followed by consumers inside and outside the mask
  task automatic t_flags();
    set_evt(RSC_EVT_ALIAS, RSC_UM_04, 1'b1);
    @(posedge clk_i);
    fw_v <= 1'b1;
    fw_m <= 6'h3C;
    @(posedge clk_i);
    fw_v <= 1'b0;
    fr_v <= 1'b1;
    fr_m <= 6'h01;
    @(posedge clk_i);
    check({31'h0, pfs}, 32'h1);
    fr_m <= 6'h0C;
    @(posedge clk_i);
    check({31'h0, pfs}, 32'h0);
    fr_v <= 1'b0;
    rd_chk(RSC_OFS_COUNT, 32'd1);
  endtask

  // two updates on every segment; one stall episode each
  task automatic t_seg();
    logic [7:0]  um [5] = '{RSC_UM_01, RSC_UM_02, RSC_UM_04, RSC_UM_08, RSC_UM_ANY};
    logic [31:0] ex [5] = '{32'd1, 32'd1, 32'd1, 32'd1, 32'd4};
    for (int i = 0; i < 5; i++) begin
      set_evt(RSC_EVT_SEG, um[i], 1'b1);
      // back-to-back updates: the second meets a still pending copy
      @(posedge clk_i);
      issue <= 4'hF;
      repeat (2) @(posedge clk_i);
      issue <= 4'h0;
      repeat (2) @(posedge clk_i);
      check({28'h0, fes}, 32'hF);
      repeat (20) @(posedge clk_i);
      check({28'h0, fes}, 32'h0);
      rd_chk(RSC_OFS_COUNT, ex[i]);
    end
  endtask

  // unlisted encodings and a disabled counter add nothing
  task automatic t_unlisted();
    logic [7:0] cd [4] = '{8'hD2, 8'hD3, 8'hD4, 8'hD2};
    logic [7:0] mk [4] = '{8'h03, 8'h02, 8'h10, 8'h02};
    for (int i = 0; i < 4; i++) begin
      set_evt(cd[i], mk[i], (i != 3));
      drive(4'hF, 3);
      rd_chk(RSC_OFS_COUNT, 32'h0);
    end
  endtask

  // watchdog: the tests need a few thousand cycles at most
  initial begin
    #(4 * 20000);
    err_total++;
    print_verdict();
  end

  // main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, fw_v, fr_v} = 5'h0;
    wb_adr = 4'h0;
    wb_sel = 4'hF;
    wb_dat = 32'h0;
    src = 4'h0;
    fw_m = 6'h0;
    fr_m = 6'h0;
    issue = 4'h0;
    err_total = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_alias();
    t_flags();
    t_seg();
    t_unlisted();
    print_verdict();
  end
endmodule
